// *** sgs_defines.vh ***
`ifndef SGS_DEFINES_VH
`define SGS_DEFINES_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define SGS_ADDR_CTRL 8'h00
`define SGS_ADDR_FORCE 8'h04
`define SGS_ADDR_REMOTE 8'h08
`define SGS_ADDR_STATUS 8'h0C
`define SGS_ADDR_LEVELS 8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define SGS_CTRL_OVR_BIT 0
`define SGS_CTRL_USED_LSB 4
`define SGS_CTRL_USED_MSB 6
`define SGS_SEL_MSB 3
`define SGS_STAT_ACT_MSB 2
`define SGS_STAT_FAIL_LSB 4
`define SGS_STAT_FAIL_MSB 6

// ****************************************************************
// codes and reset values
// ****************************************************************
`define SGS_SEL_NONE 4'h0
`define SGS_GRP_ONE 3'h0
`define SGS_USED_RST 3'h0
`define SGS_OVR_RST 1'b0
`define SGS_FAIL_RST 3'h0
`define SGS_FAIL_CFG 0
`define SGS_FAIL_FORCE 1
`define SGS_FAIL_PRIO 2

`endif

// *** sgs_selector.v ***
`include "sgs_defines.vh"
`default_nettype none

module sgs_selector (
    input wire clk,
    input wire rst_n,
    input wire [7:0] grp_req_in,
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata,
    output reg [2:0] active_grp,
    output reg grp_changed,
    output reg [7:0] dflt_load,
    output reg override_on
);

    // ****************************************************************
    // functions
    // ****************************************************************
    // one-hot of a selection code 1..8; other codes give zero
    function [7:0] sel_oh;
        input [3:0] sel;
        integer k;
        begin
            sel_oh = 8'h00;
            for (k = 0; k < 8; k = k + 1) begin
                if (sel == k + 1)
                    sel_oh[k] = 1'b1;
            end
        end
    endfunction

    // groups one to cnt+1 in use
    function [7:0] used_mask;
        input [2:0] cnt;
        integer k;
        begin
            used_mask = 8'h00;
            for (k = 0; k < 8; k = k + 1) begin
                if (k <= cnt)
                    used_mask[k] = 1'b1;
            end
        end
    endfunction

    // bit k set when any higher-priority level is held
    function [7:0] blk_mask;
        input [7:0] lvl;
        integer k;
        begin
            blk_mask = 8'h00;
            for (k = 1; k < 8; k = k + 1) begin
                blk_mask[k] = blk_mask[k-1] | lvl[k-1];
            end
        end
    endfunction

    // index of the set bit; callers pass a one-hot word
    function [2:0] oh_idx;
        input [7:0] oh;
        integer k;
        begin
            oh_idx = 3'h0;
            for (k = 0; k < 8; k = k + 1) begin
                if (oh[k])
                    oh_idx = k[2:0];
            end
        end
    endfunction

    // write strobe aimed at one register address
    function wr_hit;
        input wr;
        input [7:0] addr;
        input [7:0] target;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    // ****************************************************************
    // reset release
    // ****************************************************************
    reg rst_s1_r;
    reg rst_s_n;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s_n <= rst_s1_r;
        end
    end

    // ****************************************************************
    // activation input sync and edge detect
    // ****************************************************************
    reg [7:0] req_s1_r;
    reg [7:0] req_s2_r;
    reg [7:0] req_q_r;
    wire [7:0] lvl;
    wire [7:0] rise;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sync
            always @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    req_s1_r[g] <= 1'b0;
                    req_s2_r[g] <= 1'b0;
                    req_q_r[g] <= 1'b0;
                end else begin
                    req_s1_r[g] <= grp_req_in[g];
                    req_s2_r[g] <= req_s1_r[g];
                    req_q_r[g] <= req_s2_r[g];
                end
            end
            assign lvl[g] = req_s2_r[g];
            assign rise[g] = req_s2_r[g] & ~req_q_r[g];
        end
    endgenerate

    // ****************************************************************
    // settings
    // ****************************************************************
    reg ovr_r;
    reg ovr_q_r;
    reg [2:0] used_r;
    reg [2:0] used_q_r;
    reg [3:0] force_r;
    reg [3:0] remote_r;
    reg [2:0] fail_r;

    wire wr_ctrl = wr_hit(bus_wr, bus_addr, `SGS_ADDR_CTRL);
    wire wr_force = wr_hit(bus_wr, bus_addr, `SGS_ADDR_FORCE);
    wire wr_remote = wr_hit(bus_wr, bus_addr, `SGS_ADDR_REMOTE);
    wire wr_status = wr_hit(bus_wr, bus_addr, `SGS_ADDR_STATUS);
    wire [3:0] wsel = bus_wdata[`SGS_SEL_MSB:0];

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ovr_r <= `SGS_OVR_RST;
            used_r <= `SGS_USED_RST;
            force_r <= `SGS_SEL_NONE;
            remote_r <= `SGS_SEL_NONE;
        end else begin
            if (wr_ctrl) begin
                ovr_r <= bus_wdata[`SGS_CTRL_OVR_BIT];
                used_r <= bus_wdata[`SGS_CTRL_USED_MSB:`SGS_CTRL_USED_LSB];
            end
            if (wr_force)
                force_r <= wsel;
            if (wr_remote)
                remote_r <= wsel;
        end
    end

    // ****************************************************************
    // previous settings, for edge detection
    // ****************************************************************
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ovr_q_r <= `SGS_OVR_RST;
            used_q_r <= `SGS_USED_RST;
        end else begin
            ovr_q_r <= ovr_r;
            used_q_r <= used_r;
        end
    end

    // ****************************************************************
    // selection
    // ****************************************************************
    wire [7:0] used_m = used_mask(used_r);
    wire [7:0] used_old_m = used_mask(used_q_r);
    wire [7:0] blk = blk_mask(lvl);
    wire ovr_rise = ovr_r & ~ovr_q_r;
    wire ovr_fall = ~ovr_r & ovr_q_r;

    // forced selection acts once: on its write, or on enable
    wire force_wr_req = wr_force && (wsel != `SGS_SEL_NONE);
    wire force_req = ovr_r && (force_wr_req ||
        (ovr_rise && (force_r != `SGS_SEL_NONE)));
    wire [7:0] force_oh = sel_oh(force_wr_req ? wsel : force_r);

    wire remote_req = wr_remote && (wsel != `SGS_SEL_NONE);
    wire [7:0] remote_oh = sel_oh(wsel);

    // ****************************************************************
    // local requests
    // ****************************************************************

    // inputs ignored under override; held levels return on release
    wire [7:0] loc_cand = ovr_r ? 8'h00 :
        (rise | (ovr_fall ? lvl : 8'h00));
    wire [7:0] loc_ok = loc_cand & ~blk;
    wire [7:0] loc_win = loc_ok & (~loc_ok + 8'h01);

    // ****************************************************************
    // arbitration
    // ****************************************************************

    reg [2:0] act_nxt;
    reg [2:0] fail_ev;

    always @* begin
        act_nxt = active_grp;
        fail_ev = 3'h0;
        if (wr_force && (wsel != `SGS_SEL_NONE) && !ovr_r) begin
            fail_ev[`SGS_FAIL_FORCE] = 1'b1;
        end
        if (force_req) begin
            if ((force_oh & used_m) != 8'h00)
                act_nxt = oh_idx(force_oh);
            else
                fail_ev[`SGS_FAIL_CFG] = 1'b1;
        end else if (remote_req) begin
            if (ovr_r)
                fail_ev[`SGS_FAIL_FORCE] = 1'b1;
            else if ((remote_oh & blk) != 8'h00)
                fail_ev[`SGS_FAIL_PRIO] = 1'b1;
            else if ((remote_oh & used_m) != 8'h00)
                act_nxt = oh_idx(remote_oh);
            else
                fail_ev[`SGS_FAIL_CFG] = 1'b1;
        end else if (loc_win != 8'h00) begin
            if ((loc_win & used_m) != 8'h00)
                act_nxt = oh_idx(loc_win);
            else
                fail_ev[`SGS_FAIL_CFG] = 1'b1;
        end
        if ((loc_cand & blk) != 8'h00)
            fail_ev[`SGS_FAIL_PRIO] = 1'b1;
        // group dropped from use falls back to group one
        if (used_m[act_nxt] == 1'b0)
            act_nxt = `SGS_GRP_ONE;
    end

    // ****************************************************************
    // active group and events
    // ****************************************************************
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            active_grp <= `SGS_GRP_ONE;
            override_on <= `SGS_OVR_RST;
        end else begin
            active_grp <= act_nxt;
            override_on <= ovr_r;
        end
    end

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            grp_changed <= 1'b0;
            dflt_load <= 8'h00;
        end else begin
            grp_changed <= (act_nxt != active_grp);
            dflt_load <= used_m & ~used_old_m;
        end
    end

    // ****************************************************************
    // fail flags
    // ****************************************************************
    wire [2:0] fail_clr = wr_status ?
        bus_wdata[`SGS_STAT_FAIL_MSB:`SGS_STAT_FAIL_LSB] : 3'h0;

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            fail_r <= `SGS_FAIL_RST;
        end else begin
            // write one clears; a new event wins over the clear
            fail_r <= (fail_r & ~fail_clr) | fail_ev;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    wire [7:0] ctrl_word = {1'b0, used_r, 3'h0, ovr_r};
    wire [7:0] force_word = {4'h0, force_r};
    wire [7:0] remote_word = {4'h0, remote_r};
    wire [7:0] status_word = {1'b0, fail_r, 1'b0, active_grp};
    reg [7:0] rd_mux;

    always @* begin
        case (bus_addr)
            `SGS_ADDR_CTRL: begin
                rd_mux = ctrl_word;
            end
            `SGS_ADDR_FORCE: begin
                rd_mux = force_word;
            end
            `SGS_ADDR_REMOTE: begin
                rd_mux = remote_word;
            end
            `SGS_ADDR_STATUS: begin
                rd_mux = status_word;
            end
            `SGS_ADDR_LEVELS: begin
                rd_mux = lvl;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            bus_rdata <= 8'h00;
        end else begin
            bus_rdata <= bus_rd ? rd_mux : 8'h00;
        end
    end

endmodule // sgs_selector

`default_nettype wire

// *** sgs_selector_properties.sv ***
`default_nettype none
module sgs_selector_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] grp_req_in,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [2:0] active_grp,
    input wire logic grp_changed,
    input wire logic [7:0] dflt_load,
    input wire logic override_on
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // expected default-load mask from used-count writes
    // ********
    logic [2:0] cnt_r;
    logic [7:0] exp_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
            exp_r <= 8'h00;
        end else if (bus_wr && bus_addr == 8'h00) begin
            cnt_r <= bus_wdata[6:4];
            exp_r <= (8'hFF >> (3'h7 - bus_wdata[6:4])) & ~(8'hFF >> (3'h7 - cnt_r));
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chg_pulse_a: assert property (grp_changed == (active_grp != $past(active_grp)))
        else $error("change pulse wrong");
    stat_read_a: assert property ($past(bus_rd) && $past(bus_addr) == 8'h0C
        |-> bus_rdata[2:0] == $past(active_grp)) else $error("status group wrong");
    rd_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not idle");
    ovr_set_a: assert property (bus_wr && bus_addr == 8'h00 && bus_wdata[0]
        |-> ##[1:2] override_on) else $error("override not set");
    ovr_hold_a: assert property (override_on && $past(override_on) && $past(override_on, 2)
        && !$past(bus_wr) && !$past(bus_wr, 2) |-> $stable(active_grp))
        else $error("group moved under override");
    dflt_load_a: assert property (bus_wr && bus_addr == 8'h00
        |-> ##[1:2] dflt_load == exp_r) else $error("default load wrong");
    lvl_one_a: assert property ((grp_req_in[0] && !override_on)[*6]
        |-> active_grp == 3'h0) else $error("group one level not kept");
    remote_bad_a: assert property ((grp_req_in == 8'h00)[*4] ##0
        (bus_wr && bus_addr == 8'h08 && bus_wdata[3:0] > 4'h8) |=> $stable(active_grp))
        else $error("bad remote code moved group");
endmodule // sgs_selector_properties
`default_nettype wire

// *** sgs_field.sv ***
`default_nettype none
module sgs_field (
    input wire logic clk,
    input wire logic [7:0] lvl,
    input wire logic [7:0] pls,
    output logic [7:0] grp_req_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // activation inputs: held levels plus one-clock pulses
    // ********
    logic [7:0] pls_r = 8'h00;
    always_ff @(posedge clk) pls_r <= pls;
    assign grp_req_in = lvl | pls_r;
endmodule // sgs_field
`default_nettype wire

// *** sgs_selector_tb.sv ***
`default_nettype none
module sgs_selector_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] lvl = 8'h00;
    logic [7:0] pls = 8'h00;
    logic [31:0] seed = 32'hB029;
    logic [7:0] m;
    wire [7:0] grp_req_in;
    wire [7:0] bus_rdata;
    wire [2:0] active_grp;
    wire grp_changed;
    wire [7:0] dflt_load;
    wire override_on;
    int n_errors = 0;
    int checked = 0;
    always #25 clk = ~clk;
    sgs_field u_field (.clk(clk), .lvl(lvl), .pls(pls), .grp_req_in(grp_req_in));
    sgs_selector dut (.clk(clk), .rst_n(rst_n), .grp_req_in(grp_req_in),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .active_grp(active_grp), .grp_changed(grp_changed),
        .dflt_load(dflt_load), .override_on(override_on));
    // ********
    // helpers
    // ********
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [2:0] lo(input logic [7:0] v);
        lo = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i])
                lo = i[2:0];
        end
    endfunction
    task automatic complete_run;
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 chk("rdata", e, bus_rdata);
    endtask
    task automatic ca(input logic [2:0] e);
        repeat (5) @(posedge clk);
        #1 chk("active_grp", {5'h00, e}, {5'h00, active_grp});
    endtask
    task automatic pg(input logic [7:0] v, input logic [2:0] e);
        @(posedge clk);
        pls <= v;
        @(posedge clk);
        pls <= 8'h00;
        ca(e);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run;
    end
    // ********
    // scenarios
    // ********
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        ca(3'h0);
        for (int i = 0; i < 6; i++) begin
            rd({i[5:0], 2'b00}, 8'h00);
        end
        pg(8'h04, 3'h0);
        rd(8'h0C, 8'h10);
        wr(8'h0C, 8'h70);
        wr(8'h08, 8'h09);
        ca(3'h0);
        wr(8'h0C, 8'h70);
        wr(8'h00, 8'h70);
        @(posedge clk);
        #1 chk("dflt_load", 8'hFE, dflt_load);
        wr(8'h08, 8'h05);
        ca(3'h4);
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            m = seed[7:0] >> seed[10:8];
            if (m == 8'h00)
                m = 8'h80;
            pg(m, lo(m));
        end
        @(posedge clk) lvl <= 8'h08;
        ca(3'h3);
        pg(8'h20, 3'h3);
        rd(8'h0C, 8'h43);
        wr(8'h0C, 8'h70);
        pg(8'h02, 3'h1);
        wr(8'h08, 8'h06);
        rd(8'h0C, 8'h41);
        wr(8'h0C, 8'h70);
        @(posedge clk) lvl <= 8'h80;
        pg(8'h20, 3'h5);
        wr(8'h04, 8'h03);
        rd(8'h0C, 8'h25);
        wr(8'h00, 8'h71);
        ca(3'h2);
        chk("override_on", 8'h01, {7'h00, override_on});
        pg(8'h01, 3'h2);
        wr(8'h04, 8'h07);
        #1 chk("grp_changed", 8'h01, {7'h00, grp_changed});
        ca(3'h6);
        wr(8'h0C, 8'h70);
        wr(8'h08, 8'h01);
        rd(8'h0C, 8'h26);
        @(posedge clk) lvl <= 8'h82;
        ca(3'h6);
        wr(8'h00, 8'h70);
        ca(3'h1);
        @(posedge clk) lvl <= 8'h01;
        pg(8'h04, 3'h0);
        complete_run;
    end
endmodule // sgs_selector_tb
bind sgs_selector sgs_selector_properties u_props (.clk(clk), .rst_n(rst_n),
    .grp_req_in(grp_req_in), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .active_grp(active_grp),
    .grp_changed(grp_changed), .dflt_load(dflt_load), .override_on(override_on));
`default_nettype wire
